// file: verilog/elic_device.sv
// Operation
// [RQ1] local bus inputs level, expansion inputs edge
// [RQ2] end-of-interrupt clears in-service regardless of request
// [RQ3] still-asserted level input pends again after clear
// [RQ4] handler removes level source before end-of-interrupt
// [RQ5] clear, delay, end-of-interrupt, delay, then enable
// [RQ6] readable in-progress latch, read or explicit clear
// [RQ7] legacy shared line feeds slave replacement input
// [RQ8] replacement handler clears slave, chains legacy vector
// [RQ9] legacy handler withdraws request before master clear
// [RQ10] sharing reset port accesses change nothing
// [RQ11] classic cascaded command and status organisation
// [RQ12] non-specific clear drops highest-priority in-service bit
`timescale 1ns/1ps
module elic_device #(
    parameter logic [15:0] LEVEL_MASK       = elic_pkg::LEVEL_MASK_DEF,
    parameter bit          PROG_CLR_ON_READ = 1'b1
) (
    elic_if.dev              bus,
    input  wire logic [15:0] req_in,
    output logic [15:0]      in_service
);
    typedef struct packed {
        logic [15:0] irr;
        logic [15:0] isr;
        logic [15:0] imr;
        logic [15:0] req_prev;
        logic [1:0]  sel_isr;
        logic        prog;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        int_req;
        logic        ack_valid;
        logic [7:0]  vector;
    } elic_dev_s;

    elic_dev_s r_reg;
    elic_dev_s r_next;

    // {found, index} of the highest-priority (lowest numbered) set bit
    function automatic logic [3:0] elic_pick(input logic [7:0] v);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[i])
            begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction : elic_pick

    // levels that may still interrupt above the highest one in service
    function automatic logic [7:0] elic_above(input logic [3:0] p);
        logic [7:0] m;
        m = 8'hff;
        if (p[3])
        begin
            m = (8'h01 << p[2:0]) - 8'h01;
        end
        return m;
    endfunction : elic_above

    logic [15:0] eff_req;
    logic [3:0]  s_isr_p;
    logic [3:0]  s_cand;
    logic [3:0]  m_isr_p;
    logic [3:0]  m_cand;
    logic [7:0]  m_pend;
    logic        half;
    logic [7:0]  isr8;
    logic [3:0]  isr8_p;

    always_comb
    begin
        r_next = r_reg;
        r_next.rvalid = 1'b0;
        r_next.ack_valid = 1'b0;
        half = 1'b0;
        isr8 = 8'h00;
        isr8_p = 4'h0;

        eff_req = req_in;
        eff_req[elic_pkg::REPLACEMENT_IN] = req_in[elic_pkg::REPLACEMENT_IN]
                                          | req_in[elic_pkg::LEGACY_IN]; // RQ7
        // master input 2 carries the slave cascade, not a pin
        eff_req[elic_pkg::CASCADE_IN] = 1'b0; // RQ11
        r_next.req_prev = eff_req;

        // fully nested priority, slave stands in at master level 2
        s_isr_p = elic_pick(r_reg.isr[15:8]);
        s_cand  = elic_pick(r_reg.irr[15:8] & ~r_reg.imr[15:8] & elic_above(s_isr_p));
        m_pend  = r_reg.irr[7:0] & ~r_reg.imr[7:0];
        m_pend[elic_pkg::CASCADE_IN] = s_cand[3] & ~r_reg.imr[elic_pkg::CASCADE_IN];
        m_isr_p = elic_pick(r_reg.isr[7:0]);
        m_cand  = elic_pick(m_pend & elic_above(m_isr_p));

        if (bus.io_valid)
        begin
            if (bus.io_write)
            begin
                if (bus.io_addr == elic_pkg::MASTER_CMD_ADDR
                    || bus.io_addr == elic_pkg::SLAVE_CMD_ADDR) // RQ11
                begin
                    half = (bus.io_addr == elic_pkg::SLAVE_CMD_ADDR);
                    isr8 = half ? r_reg.isr[15:8] : r_reg.isr[7:0];
                    isr8_p = elic_pick(isr8);
                    // clearing ignores whether the request is still there
                    if (bus.io_wdata == elic_pkg::CMD_END_NONSPEC && isr8_p[3]) // RQ2
                    begin
                        isr8[isr8_p[2:0]] = 1'b0; // RQ12
                    end
                    else if (bus.io_wdata[7:3] == elic_pkg::CMD_END_SPEC_HI)
                    begin
                        isr8[bus.io_wdata[2:0]] = 1'b0; // RQ2
                    end
                    else if (bus.io_wdata == elic_pkg::CMD_READ_IRR)
                    begin
                        r_next.sel_isr[half] = 1'b0;
                    end
                    else if (bus.io_wdata == elic_pkg::CMD_READ_ISR)
                    begin
                        r_next.sel_isr[half] = 1'b1;
                    end
                    if (half)
                    begin
                        r_next.isr[15:8] = isr8;
                    end
                    else
                    begin
                        r_next.isr[7:0] = isr8;
                    end
                end
                else if (bus.io_addr == elic_pkg::MASTER_DATA_ADDR)
                begin
                    r_next.imr[7:0] = bus.io_wdata;
                end
                else if (bus.io_addr == elic_pkg::SLAVE_DATA_ADDR)
                begin
                    r_next.imr[15:8] = bus.io_wdata;
                end
                else if (bus.io_addr == elic_pkg::PROG_LATCH_ADDR && !PROG_CLR_ON_READ)
                begin
                    r_next.prog = 1'b0; // RQ6
                end
                // any other address, sharing reset ports included, is ignored
            end
            else
            begin
                r_next.rvalid = 1'b1;
                unique case (bus.io_addr)
                    elic_pkg::MASTER_CMD_ADDR:
                        r_next.rdata = r_reg.sel_isr[0] ? r_reg.isr[7:0] : r_reg.irr[7:0];
                    elic_pkg::SLAVE_CMD_ADDR:
                        r_next.rdata = r_reg.sel_isr[1] ? r_reg.isr[15:8] : r_reg.irr[15:8];
                    elic_pkg::MASTER_DATA_ADDR:
                        r_next.rdata = r_reg.imr[7:0];
                    elic_pkg::SLAVE_DATA_ADDR:
                        r_next.rdata = r_reg.imr[15:8];
                    elic_pkg::PROG_LATCH_ADDR:
                    begin
                        r_next.rdata = {7'h00, r_reg.prog}; // RQ6
                        if (PROG_CLR_ON_READ)
                        begin
                            r_next.prog = 1'b0; // RQ6
                        end
                    end
                    default:
                        r_next.rdata = 8'h00; // RQ10
                endcase
            end
        end

        // acknowledge: later than the i/o clears, so a new latch set wins
        if (bus.int_ack)
        begin
            r_next.ack_valid = 1'b1;
            r_next.prog = 1'b1; // RQ6
            if (m_cand[3] && m_cand[2:0] == 3'(elic_pkg::CASCADE_IN))
            begin
                r_next.isr[elic_pkg::CASCADE_IN] = 1'b1;
                r_next.isr[8 + int'(s_cand[2:0])] = 1'b1;
                r_next.irr[8 + int'(s_cand[2:0])] = 1'b0;
                r_next.vector = elic_pkg::SLAVE_VEC_BASE + {5'h00, s_cand[2:0]};
            end
            else if (m_cand[3])
            begin
                r_next.isr[m_cand[2:0]] = 1'b1;
                r_next.irr[m_cand[2:0]] = 1'b0;
                r_next.vector = elic_pkg::MASTER_VEC_BASE + {5'h00, m_cand[2:0]};
            end
            else
            begin
                // request vanished before the acknowledge: spurious level 7
                r_next.vector = elic_pkg::MASTER_VEC_BASE + 8'h07;
            end
        end

        // request capture after the acknowledge clear, so a new edge survives
        for (int i = 0; i < 16; i++)
        begin
            if (LEVEL_MASK[i])
            begin
                // a level still high after the clear pends again at once
                r_next.irr[i] = eff_req[i]; // RQ1 RQ3
            end
            else if (eff_req[i] && !r_reg.req_prev[i])
            begin
                r_next.irr[i] = 1'b1; // RQ1
            end
        end
        r_next.irr[elic_pkg::CASCADE_IN] = 1'b0;

        r_next.int_req = m_cand[3] & ~bus.int_ack;
    end

    always_ff @(posedge bus.clk)
    begin
        if (!bus.rst_b)
        begin
            r_reg <= '0;
            r_reg.imr <= elic_pkg::MASK_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign bus.io_rdata   = r_reg.rdata;
    assign bus.io_rvalid  = r_reg.rvalid;
    assign bus.int_req    = r_reg.int_req;
    assign bus.ack_valid  = r_reg.ack_valid;
    assign bus.ack_vector = r_reg.vector;
    assign in_service     = r_reg.isr;
endmodule : elic_device

// file: common/elic_pkg.sv
package elic_pkg;
    // i/o map of the controller pair
    localparam logic [15:0] MASTER_CMD_ADDR  = 16'h0020;
    localparam logic [15:0] MASTER_DATA_ADDR = 16'h0021;
    localparam logic [15:0] SLAVE_CMD_ADDR   = 16'h00a0;
    localparam logic [15:0] SLAVE_DATA_ADDR  = 16'h00a1;
    localparam logic [15:0] PROG_LATCH_ADDR  = 16'h0500;
    // positive-edge sharing reset ports: high nibbles of 02fx and 06fx
    localparam logic [11:0] SHARE_RST_A      = 12'h02f;
    localparam logic [11:0] SHARE_RST_B      = 12'h06f;
    // command bytes on the command port
    localparam logic [7:0]  CMD_END_NONSPEC  = 8'h20;
    localparam logic [4:0]  CMD_END_SPEC_HI  = 5'h0c;
    localparam logic [7:0]  CMD_READ_IRR     = 8'h0a;
    localparam logic [7:0]  CMD_READ_ISR     = 8'h0b;
    // vectors
    localparam logic [7:0]  MASTER_VEC_BASE  = 8'h08;
    localparam logic [7:0]  SLAVE_VEC_BASE   = 8'h70;
    localparam logic [7:0]  VEC_REPLACEMENT  = 8'h71;
    localparam logic [7:0]  VEC_LEGACY       = 8'h0a;
    // input numbering
    localparam int          CASCADE_IN       = 2;
    localparam int          LEGACY_IN        = 2;
    localparam int          REPLACEMENT_IN   = 9;
    // reset values and defaults
    localparam logic [15:0] MASK_RST         = 16'h0000;
    localparam logic [15:0] LEVEL_MASK_DEF   = 16'h1c00;
    // handler i/o delay
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          IO_DELAY_NS      = 1000;
    localparam int          IO_DELAY_CYC     = (IO_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : elic_pkg

// file: common/elic_if.sv
`timescale 1ns/1ps
interface elic_if (
    input wire logic clk,
    input wire logic rst_b
);
    logic        io_valid;
    logic        io_write;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        io_rvalid;
    logic        int_req;
    logic        int_ack;
    logic        ack_valid;
    logic [7:0]  ack_vector;

    modport dev (
        input  clk,
        input  rst_b,
        input  io_valid,
        input  io_write,
        input  io_addr,
        input  io_wdata,
        output io_rdata,
        output io_rvalid,
        output int_req,
        input  int_ack,
        output ack_valid,
        output ack_vector
    );

    modport cpu (
        input  clk,
        input  rst_b,
        output io_valid,
        output io_write,
        output io_addr,
        output io_wdata,
        input  io_rdata,
        input  io_rvalid,
        input  int_req,
        output int_ack,
        input  ack_valid,
        input  ack_vector
    );
endinterface : elic_if

// file: verilog/elic_host.sv
`timescale 1ns/1ps
module elic_host #(
    parameter int IO_DELAY = elic_pkg::IO_DELAY_CYC
) (
    elic_if.cpu        bus,
    input  wire logic  svc_done,
    output logic       svc_start,
    output logic [7:0] svc_vector,
    output logic       cpu_int_en
);
    typedef enum logic [3:0] {
        H_IDLE, H_VEC, H_DLY0, H_SVC, H_DLY1, H_END_M, H_DLY2
    } elic_hst_e;

    typedef struct packed {
        elic_hst_e   st;
        logic [15:0] cnt;
        logic        slave;
        logic        chain;
        logic        ien;
        logic        ack;
        logic        start;
        logic [7:0]  vec;
        logic        io_valid;
        logic        io_write;
        logic [15:0] io_addr;
        logic [7:0]  io_wdata;
    } elic_hst_s;

    elic_hst_s h_reg;
    elic_hst_s h_next;

    always_comb
    begin
        h_next = h_reg;
        h_next.ack = 1'b0;
        h_next.start = 1'b0;
        h_next.io_valid = 1'b0;
        h_next.io_write = 1'b1;
        h_next.cnt = h_reg.cnt - 16'h0001;
        unique case (h_reg.st)
            H_IDLE:
                if (bus.int_req && h_reg.ien)
                begin
                    h_next.ack = 1'b1;
                    h_next.ien = 1'b0;
                    h_next.st = H_VEC;
                end
            H_VEC:
                if (bus.ack_valid)
                begin
                    h_next.vec = bus.ack_vector;
                    h_next.slave = bus.ack_vector[7:3] == elic_pkg::SLAVE_VEC_BASE[7:3];
                    h_next.chain = bus.ack_vector == elic_pkg::VEC_REPLACEMENT;
                    if (bus.ack_vector == elic_pkg::VEC_REPLACEMENT)
                    begin
                        // release the slave first, then run the legacy handler
                        h_next.io_valid = 1'b1; // RQ8
                        h_next.io_addr = elic_pkg::SLAVE_CMD_ADDR;
                        h_next.io_wdata = elic_pkg::CMD_END_NONSPEC;
                        h_next.slave = 1'b0;
                        h_next.cnt = 16'(IO_DELAY);
                        h_next.st = H_DLY0;
                    end
                    else
                    begin
                        // the handler reads the in-progress latch as it starts
                        h_next.io_valid = 1'b1;
                        h_next.io_write = 1'b0;
                        h_next.io_addr = elic_pkg::PROG_LATCH_ADDR;
                        h_next.start = 1'b1;
                        h_next.st = H_SVC;
                    end
                end
            H_DLY0:
                if (h_reg.cnt == 16'h0002)
                begin
                    // old sharing software re-arms its reset port; must be harmless
                    h_next.io_valid = 1'b1;
                    h_next.io_addr = {elic_pkg::SHARE_RST_A, 4'(elic_pkg::LEGACY_IN)};
                    h_next.io_wdata = elic_pkg::CMD_END_NONSPEC;
                end
                else if (h_reg.cnt == 16'h0001)
                begin
                    h_next.vec = elic_pkg::VEC_LEGACY; // RQ8
                    h_next.io_valid = 1'b1;
                    h_next.io_write = 1'b0;
                    h_next.io_addr = elic_pkg::PROG_LATCH_ADDR;
                    h_next.start = 1'b1;
                    h_next.st = H_SVC;
                end
            H_SVC:
                // user raises svc_done once the source has dropped its request
                if (svc_done) // RQ4 RQ9
                begin
                    h_next.cnt = 16'(IO_DELAY);
                    h_next.st = H_DLY1; // RQ5
                end
            H_DLY1:
                if (h_reg.cnt == 16'h0001)
                begin
                    h_next.io_valid = 1'b1;
                    h_next.io_wdata = elic_pkg::CMD_END_NONSPEC;
                    h_next.io_addr = h_reg.slave ? elic_pkg::SLAVE_CMD_ADDR
                                                 : elic_pkg::MASTER_CMD_ADDR;
                    h_next.st = h_reg.slave ? H_DLY1 : H_END_M;
                    h_next.cnt = 16'h0001;
                    h_next.slave = 1'b0;
                end
            H_END_M:
            begin
                h_next.cnt = 16'(IO_DELAY);
                h_next.st = H_DLY2; // RQ5
            end
            H_DLY2:
                if (h_reg.cnt == 16'h0001)
                begin
                    h_next.ien = 1'b1; // RQ5
                    h_next.st = H_IDLE;
                end
        endcase
    end

    always_ff @(posedge bus.clk)
    begin
        if (!bus.rst_b)
        begin
            h_reg <= '0;
            h_reg.st <= H_IDLE;
            h_reg.ien <= 1'b1;
        end
        else
        begin
            h_reg <= h_next;
        end
    end

    assign bus.io_valid = h_reg.io_valid;
    assign bus.io_write = h_reg.io_write;
    assign bus.io_addr  = h_reg.io_addr;
    assign bus.io_wdata = h_reg.io_wdata;
    assign bus.int_ack  = h_reg.ack;
    assign svc_start    = h_reg.start;
    assign svc_vector   = h_reg.vec;
    assign cpu_int_en   = h_reg.ien;
endmodule : elic_host

// file: bench/elic_assertions.sv
`timescale 1ns/1ps
module elic_assertions #(
    parameter int IO_DELAY = 4
) (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        io_valid,
    input wire logic        io_write,
    input wire logic [15:0] io_addr,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_rvalid,
    input wire logic        int_req,
    input wire logic        int_ack,
    input wire logic        ack_valid,
    input wire logic [7:0]  ack_vector
);
    logic [7:0] last_vec_reg;
    int         quiet_reg;
    logic       m_end_w;
    logic       s_end_w;

    assign m_end_w = io_valid && io_write && io_addr == elic_pkg::MASTER_CMD_ADDR;
    assign s_end_w = io_valid && io_write && io_addr == elic_pkg::SLAVE_CMD_ADDR;

    // counts down the i/o delay that follows a master clear
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            last_vec_reg <= 8'h00;
            quiet_reg    <= 0;
        end
        else
        begin
            if (ack_valid)
                last_vec_reg <= ack_vector;
            if (m_end_w)
                quiet_reg <= IO_DELAY;
            else if (quiet_reg > 0)
                quiet_reg <= quiet_reg - 1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_slave_end;
        s_end_w && io_wdata == elic_pkg::CMD_END_NONSPEC;
    endsequence
    sequence s_master_end;
        m_end_w && io_wdata == elic_pkg::CMD_END_NONSPEC;
    endsequence

    a_ack_gives_vector: assert property (int_ack |=> ack_valid)
        else $error("acknowledge got no vector");
    a_req_drops_ack: assert property (int_ack |=> !int_req)
        else $error("request still high after acknowledge");
    a_ack_follows_req: assert property (int_ack |-> $past(int_req))
        else $error("acknowledge without request");
    a_vector_range: assert property
        (ack_valid |-> (ack_vector[7:3] == 5'h01 || ack_vector[7:3] == 5'h0e))
        else $error("vector outside both controller ranges");
    a_vector_holds: assert property (!ack_valid |-> $stable(ack_vector))
        else $error("vector changed without acknowledge");
    a_chain_slave_end: assert property
        (ack_valid && ack_vector == elic_pkg::VEC_REPLACEMENT |=> s_slave_end)
        else $error("replacement vector not followed by slave clear");
    // outside the replacement path, the host issues the master clear in the cycle right after the slave clear
    a_slave_then_master: assert property
        (s_end_w && last_vec_reg != elic_pkg::VEC_REPLACEMENT |-> ##1 s_master_end)
        else $error("slave clear not followed by master clear");
    a_end_delay_quiet: assert property (quiet_reg > 0 |-> !int_ack && !io_valid)
        else $error("activity inside the delay after clear");
    a_end_nonspec_only: assert property
        (io_valid && io_write |-> io_wdata == elic_pkg::CMD_END_NONSPEC)
        else $error("command byte is not a non-specific clear");
    a_rvalid_cause: assert property (io_rvalid |-> $past(io_valid) && !$past(io_write))
        else $error("read answer without read");
    a_rdata_holds: assert property (!io_rvalid |-> $stable(io_rdata))
        else $error("read data changed without answer");
endmodule : elic_assertions

// file: bench/test_edge_level_interrupt_control.sv
`timescale 1ns/1ps
module test_edge_level_interrupt_control;
    logic        clk;
    logic        rst_b;
    logic [15:0] req_in;
    logic [15:0] in_service;
    logic        svc_done;
    logic        svc_start;
    logic [7:0]  svc_vector;
    logic        cpu_int_en;
    logic [7:0]  ack_seen;
    logic        s_end_seen;
    int          fails;
    int          compares;

    elic_if bus (.clk(clk), .rst_b(rst_b));
    elic_device elic_device_i (.bus(bus), .req_in(req_in), .in_service(in_service));
    // short i/o delay keeps the run brief; expectations use the same 4
    elic_host #(.IO_DELAY(4)) elic_host_i (.bus(bus), .svc_done(svc_done),
        .svc_start(svc_start), .svc_vector(svc_vector), .cpu_int_en(cpu_int_en));
    elic_assertions #(.IO_DELAY(4)) elic_assertions_i (.clk(clk), .rst_b(rst_b),
        .io_valid(bus.io_valid), .io_write(bus.io_write), .io_addr(bus.io_addr),
        .io_wdata(bus.io_wdata), .io_rdata(bus.io_rdata), .io_rvalid(bus.io_rvalid),
        .int_req(bus.int_req), .int_ack(bus.int_ack), .ack_valid(bus.ack_valid),
        .ack_vector(bus.ack_vector));

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask : check

    task automatic print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic take_irq;
        int n;
        n = 0;
        s_end_seen = 1'b0;
        while (svc_start !== 1'b1 && n < 100)
        begin
            tick();
            n++;
            if (bus.ack_valid === 1'b1)
                ack_seen = bus.ack_vector;
            if (bus.io_valid === 1'b1 && bus.io_addr === elic_pkg::SLAVE_CMD_ADDR)
                s_end_seen = 1'b1;
        end
        check("svc_start", 16'(svc_start), 16'h0001);
        // the handler's latch read is answered one cycle after the start
        tick();
        check("latch_rvalid", 16'(bus.io_rvalid), 16'h0001);
        check("latch_read", 16'(bus.io_rdata), 16'h0001);
        check("latch_cleared", 16'(elic_device_i.r_reg.prog), 16'h0000);
    endtask : take_irq

    task automatic finish_irq;
        int n;
        n = 0;
        svc_done = 1'b1;
        while (cpu_int_en !== 1'b1 && n < 100)
        begin
            tick();
            n++;
        end
        svc_done = 1'b0;
        check("cpu_int_en", 16'(cpu_int_en), 16'h0001);
        check("two_io_delays", 16'(n > 8), 16'h0001);
    endtask : finish_irq

    task automatic test_edge_pair;
        req_in = 16'h0028;
        take_irq();
        check("svc_vector", 16'(svc_vector), 16'(elic_pkg::MASTER_VEC_BASE + 8'h03));
        check("in_service", in_service, 16'h0008);
        finish_irq();
        // level 5 is only offered once the clear has dropped level 3
        take_irq();
        check("svc_vector", 16'(svc_vector), 16'(elic_pkg::MASTER_VEC_BASE + 8'h05));
        check("in_service", in_service, 16'h0020);
        finish_irq();
        repeat (6) tick();
        check("int_req", 16'(bus.int_req), 16'h0000);
        check("in_service", in_service, 16'h0000);
        req_in = 16'h0000;
        $display("done test_edge_pair");
    endtask : test_edge_pair

    task automatic test_level_repend;
        req_in = 16'h0400;
        take_irq();
        check("svc_vector", {8'h00, svc_vector}, {8'h00, elic_pkg::SLAVE_VEC_BASE + 8'h02});
        check("in_service", in_service, 16'h0404);
        finish_irq();
        take_irq();
        check("svc_vector", {8'h00, svc_vector}, {8'h00, elic_pkg::SLAVE_VEC_BASE + 8'h02});
        req_in = 16'h0000;
        finish_irq();
        repeat (6) tick();
        check("int_req", 16'(bus.int_req), 16'h0000);
        check("in_service", in_service, 16'h0000);
        $display("done test_level_repend");
    endtask : test_level_repend

    task automatic test_legacy_share(input logic [15:0] line);
        req_in = line;
        take_irq();
        check("ack_vector", {8'h00, ack_seen}, {8'h00, elic_pkg::VEC_REPLACEMENT});
        check("slave_end", 16'(s_end_seen), 16'h0001);
        check("svc_vector", {8'h00, svc_vector}, {8'h00, elic_pkg::VEC_LEGACY});
        // the sharing reset port write made during the delay must not touch service
        check("in_service", in_service, 16'h0004);
        req_in = 16'h0000;
        finish_irq();
        check("in_service", in_service, 16'h0000);
        $display("done test_legacy_share %h", line);
    endtask : test_legacy_share

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        rst_b = 1'b0;
        req_in = 16'h0000;
        svc_done = 1'b0;
        ack_seen = 8'h00;
        s_end_seen = 1'b0;
        fails = 0;
        compares = 0;
        repeat (10) tick();
        rst_b = 1'b1;
        check("in_service", in_service, 16'h0000);
        test_edge_pair();
        test_level_repend();
        test_legacy_share(16'h0004);
        test_legacy_share(16'h0200);
        print_verdict();
    end

    initial
    begin
        repeat (3000) @(posedge clk);
        fails++;
        print_verdict();
    end
endmodule : test_edge_level_interrupt_control
